/* gptm_pkg.sv */
/*
  Shared constants and types of the three-timer block: register
  offsets, reset values, base sampling figures, mode codes and the
  packed carriers for the control word and the register port.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package gptm_pkg;
  localparam int GPTM_N = 3;
  localparam int GPTM_AUX1 = 0;
  localparam int GPTM_CORE = 1;
  localparam int GPTM_AUX2 = 2;
  // word offsets on the register port
  localparam logic [3:0] GPTM_CTL0 = 4'h0;
  localparam logic [3:0] GPTM_CNT0 = 4'h3;
  localparam logic [3:0] GPTM_STAT = 4'h6;
  // reset values
  localparam logic [15:0] GPTM_CTL_RST = 16'h0000;
  localparam logic [15:0] GPTM_CNT_RST = 16'h0000;
  // cycles per input sample, and the tick phase of the prescaler
  localparam int GPTM_RES = 4;
  localparam logic [1:0] GPTM_TICK = 2'h3;
  localparam int GPTM_PRE_W = 10;

  typedef enum logic [2:0] {
    GPTM_TIMER,
    GPTM_COUNTER,
    GPTM_GATED,
    GPTM_INCR,
    GPTM_RELOAD,
    GPTM_CAPTURE
  } gptm_mode_t;

  // per-timer control word
  typedef struct packed {
    logic [4:0] rsv;
    logic lat_oe;
    logic gate_hi;
    logic ext_dir;
    logic down;
    logic run;
    logic [2:0] sel;
    gptm_mode_t mode;
  } gptm_ctl_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } gptm_bus_t;
endpackage
`default_nettype wire

/* gptm_top.sv */
/*
  Three 16-bit timers: one core timer with a toggle latch and two
  auxiliary timers that count or act as capture/reload registers.
  Assumes pins are asynchronous to clk and a register master that
  keeps strobes one cycle long and never both at once.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - three independent 16-bit timers, chainable within the block
// - each timer picks timer, gated, counter or incremental mode
// - timer mode counts system clock through a programmable prescaler
// - counter mode counts external edges on the timer's own pin
// - gated mode counts prescaled ticks only while the gate level holds
// - each timer owns one input pin, used as gate or count clock
// - finest resolution is one count per four system clocks
// - direction set by software, optionally altered by direction pin
// - incremental mode derives count and direction from phases A and B
// - toggle latch flips on each core overflow and underflow in a cycle without a status write
// - toggle latch can drive a dedicated output pin
// - toggle latch can clock both auxiliary timers
// - auxiliary timers can act as capture or reload registers
// - an auxiliary timer in capture or reload role does not count
// - capture loads the core value on the auxiliary pin's edge
// - reload loads the core from an auxiliary on pin or latch edge
// - opposite latch edges reloading from both auxiliaries make PWM
// - timers chain to measure intervals beyond sixteen bits
module gptm_top #(
  parameter int PRE_W = gptm_pkg::GPTM_PRE_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire gptm_pkg::gptm_bus_t bus,
  output logic [15:0] rd_data,
  input wire logic [2:0] timer_input_pin,
  input wire logic [2:0] direction_input_pin,
  output logic toggle_output_pin
);

  // edge select: bit0 rising, bit1 falling
  function automatic logic edge_hit(input logic [1:0] s, input logic r,
                                    input logic f);
    return (s[0] & r) | (s[1] & f);
  endfunction

  // prescaler hit every GPTM_RES << ps cycles
  function automatic logic pre_hit(input logic [PRE_W-1:0] c,
                                   input logic [2:0] ps);
    logic [PRE_W-1:0] m;
    m = (PRE_W'(gptm_pkg::GPTM_RES) << ps) - PRE_W'(1);
    return &(c | ~m);
  endfunction

  gptm_pkg::gptm_ctl_t ctl [3];
  logic [15:0] cnt [3];
  logic [15:0] next_cnt [3];
  logic [15:0] step [3];
  logic [2:0] in_q1, in_q2, in_s, in_p;
  logic [2:0] dir_q1, dir_q2, dir_s, dir_p;
  logic [PRE_W-1:0] pre_cnt;
  logic smp_q, smp_v, tick;
  logic lat, lat_p, lat_r, lat_f, next_lat;
  logic [2:0] en_v, dn_v, ovf, unf, rl, cap, wr_cnt, wr_ctl;
  logic wr_stat, core_ld;
  logic [15:0] core_src, rd_mux, stat_word;

  // base tick every four cycles, samples valid the cycle after
  assign tick = ce & (pre_cnt[1:0] == gptm_pkg::GPTM_TICK);
  assign smp_v = smp_q & ce;

  // two-stage synchronisers, then sampling on the base tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_q1 <= 3'h0;
      in_q2 <= 3'h0;
      dir_q1 <= 3'h0;
      dir_q2 <= 3'h0;
      in_s <= 3'h0;
      in_p <= 3'h0;
      dir_s <= 3'h0;
      dir_p <= 3'h0;
      smp_q <= 1'b0;
      pre_cnt <= '0;
    end else if (ce) begin
      in_q1 <= timer_input_pin;
      in_q2 <= in_q1;
      dir_q1 <= direction_input_pin;
      dir_q2 <= dir_q1;
      smp_q <= tick;
      pre_cnt <= pre_cnt + PRE_W'(1);
      if (tick) begin
        in_s <= in_q2;
        in_p <= in_s;
        dir_s <= dir_q2;
        dir_p <= dir_s;
      end
    end
  end

  // toggle latch edges for aux clocking and reload triggers
  assign lat_r = ce & lat & ~lat_p;
  assign lat_f = ce & ~lat & lat_p;

  // per-timer mode decode and count step
  genvar gi;
  for (gi = 0; gi < gptm_pkg::GPTM_N; gi++) begin : g_tmr
    gptm_pkg::gptm_ctl_t c;
    logic pin_r, pin_f, q_ev, q_up, src_ev, aux;
    assign c = ctl[gi];
    assign aux = (gi != gptm_pkg::GPTM_CORE);
    assign pin_r = smp_v & in_s[gi] & ~in_p[gi];
    assign pin_f = smp_v & ~in_s[gi] & in_p[gi];
    // exactly one phase moved: one quadrature step
    assign q_ev = smp_v & ((in_s[gi] ^ in_p[gi]) ^ (dir_s[gi] ^ dir_p[gi]));
    assign q_up = in_p[gi] ^ dir_s[gi];
    // count source: own pin, or the latch for an auxiliary timer
    assign src_ev = (c.sel[2] && aux) ? edge_hit(c.sel[1:0], lat_r, lat_f)
                                      : edge_hit(c.sel[1:0], pin_r, pin_f);
    assign dn_v[gi] = (c.mode == gptm_pkg::GPTM_INCR) ? (~q_up ^ c.down)
                      : (c.down ^ (c.ext_dir & dir_s[gi]));
    // count enable per mode; roles and unknown codes stop the count
    assign en_v[gi] = ce & c.run & (
      (c.mode == gptm_pkg::GPTM_TIMER) ? pre_hit(pre_cnt, c.sel) :
      (c.mode == gptm_pkg::GPTM_GATED) ?
        (pre_hit(pre_cnt, c.sel) & (in_s[gi] == c.gate_hi)) :
      (c.mode == gptm_pkg::GPTM_COUNTER) ? src_ev :
      (c.mode == gptm_pkg::GPTM_INCR) ? q_ev : 1'b0);
    assign step[gi] = dn_v[gi] ? cnt[gi] - 16'h0001 : cnt[gi] + 16'h0001;
    assign ovf[gi] = en_v[gi] & ~dn_v[gi] & (&cnt[gi]);
    assign unf[gi] = en_v[gi] & dn_v[gi] & ~(|cnt[gi]);
    // roles of an auxiliary timer
    assign rl[gi] = aux & (c.mode == gptm_pkg::GPTM_RELOAD) & src_ev;
    assign cap[gi] = aux & (c.mode == gptm_pkg::GPTM_CAPTURE)
                     & edge_hit(c.sel[1:0], pin_r, pin_f);
    assign wr_cnt[gi] = bus.wr & (bus.addr == gptm_pkg::GPTM_CNT0 + 4'(gi));
    assign wr_ctl[gi] = bus.wr & (bus.addr == gptm_pkg::GPTM_CTL0 + 4'(gi));
    // write beats reload or capture, which beat counting
    assign next_cnt[gi] = wr_cnt[gi] ? bus.wdata :
                          (!aux && core_ld) ? core_src :
                          cap[gi] ? cnt[gptm_pkg::GPTM_CORE] :
                          en_v[gi] ? step[gi] : cnt[gi];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cnt[gi] <= gptm_pkg::GPTM_CNT_RST;
        ctl[gi] <= gptm_pkg::GPTM_CTL_RST;
      end else if (ce) begin
        cnt[gi] <= next_cnt[gi];
        if (wr_ctl[gi]) begin
          ctl[gi] <= bus.wdata;
        end
      end
    end
  end

  // core reload source, first auxiliary first
  assign core_ld = rl[gptm_pkg::GPTM_AUX1] | rl[gptm_pkg::GPTM_AUX2];
  assign core_src = rl[gptm_pkg::GPTM_AUX1] ? cnt[gptm_pkg::GPTM_AUX1]
                                            : cnt[gptm_pkg::GPTM_AUX2];

  // toggle latch: software preset, else flip on core wrap
  assign wr_stat = bus.wr & (bus.addr == gptm_pkg::GPTM_STAT);
  assign next_lat = wr_stat ? bus.wdata[0]
                  : lat ^ (ovf[gptm_pkg::GPTM_CORE] | unf[gptm_pkg::GPTM_CORE]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat <= 1'b0;
      lat_p <= 1'b0;
      toggle_output_pin <= 1'b0;
    end else if (ce) begin
      lat <= next_lat;
      lat_p <= lat;
      toggle_output_pin <= lat & ctl[gptm_pkg::GPTM_CORE].lat_oe;
    end
  end

  // status: latch, effective directions, sampled pins
  assign stat_word = {6'h00, dir_s, in_s, dn_v, lat};

  // read selection
  always_comb begin
    if (bus.addr == gptm_pkg::GPTM_CTL0) begin
      rd_mux = ctl[0];
    end else if (bus.addr == gptm_pkg::GPTM_CTL0 + 4'h1) begin
      rd_mux = ctl[1];
    end else if (bus.addr == gptm_pkg::GPTM_CTL0 + 4'h2) begin
      rd_mux = ctl[2];
    end else if (bus.addr == gptm_pkg::GPTM_CNT0) begin
      rd_mux = cnt[0];
    end else if (bus.addr == gptm_pkg::GPTM_CNT0 + 4'h1) begin
      rd_mux = cnt[1];
    end else if (bus.addr == gptm_pkg::GPTM_CNT0 + 4'h2) begin
      rd_mux = cnt[2];
    end else if (bus.addr == gptm_pkg::GPTM_STAT) begin
      rd_mux = stat_word;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= bus.rd ? rd_mux : 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_core_quiet;
    !en_v[1] [*3];
  endsequence

  sequence s_core_wrap;
    (ovf[1] || unf[1]) && !wr_stat;
  endsequence

  wrap_up_a: assert property (
    (ovf[1] && !wr_cnt[1] && !core_ld) |=> cnt[1] == 16'h0000)
    else $error("core overflow did not wrap to zero");

  wrap_down_a: assert property (
    (unf[1] && !wr_cnt[1] && !core_ld) |=> cnt[1] == 16'hffff)
    else $error("core underflow did not wrap to all ones");

  latch_flip_a: assert property (
    s_core_wrap |=> lat != $past(lat))
    else $error("toggle latch missed a core wrap");

  latch_hold_a: assert property (
    (!(ovf[1] || unf[1]) && !wr_stat) |=> $stable(lat))
    else $error("toggle latch moved without a wrap");

  out_pin_a: assert property (
    ce |=> toggle_output_pin == $past(lat && ctl[1].lat_oe))
    else $error("output pin does not follow the latch");

  core_res_a: assert property (
    en_v[1] |=> s_core_quiet)
    else $error("core counted faster than one per four cycles");

  role_stop_a: assert property (
    (ctl[0].mode == gptm_pkg::GPTM_RELOAD && !wr_cnt[0]) |=> $stable(cnt[0]))
    else $error("auxiliary timer counted in reload role");

  capture_a: assert property (
    (cap[0] && !wr_cnt[0]) |=> cnt[0] == $past(cnt[1]))
    else $error("capture did not take the core value");

  reload_a: assert property (
    (rl[2] && !rl[0] && !wr_cnt[1]) |=> cnt[1] == $past(cnt[2]))
    else $error("reload did not load the core");

  gate_a: assert property (
    (ctl[0].mode == gptm_pkg::GPTM_GATED && in_s[0] != ctl[0].gate_hi) |-> !en_v[0])
    else $error("gated timer counted with gate closed");

  // input path: the first flop feeds only the second, samples only on the tick
  sync_pass_a: assert property (
    ce |=> in_q2 == $past(in_q1) && dir_q2 == $past(dir_q1))
    else $error("synchroniser stage skipped");

  sample_take_a: assert property (
    tick |=> in_s == $past(in_q2) && dir_s == $past(dir_q2))
    else $error("sample did not take the synchronised pins");

  sample_hold_a: assert property (
    !tick |=> $stable(in_s) && $stable(dir_s))
    else $error("pins sampled off the base tick");

  tick_gap_a: assert property (
    tick |=> !tick [*3])
    else $error("base tick came early");

  // core count: one step per enable, otherwise held
  sequence s_core_up;
    en_v[1] && !dn_v[1] && !wr_cnt[1] && !core_ld;
  endsequence

  sequence s_core_down;
    en_v[1] && dn_v[1] && !wr_cnt[1] && !core_ld;
  endsequence

  sequence s_core_idle;
    !en_v[1] && !wr_cnt[1] && !core_ld;
  endsequence

  step_up_a: assert property (
    s_core_up |=> cnt[1] == $past(cnt[1]) + 16'h0001)
    else $error("core did not step up by one");

  step_down_a: assert property (
    s_core_down |=> cnt[1] == $past(cnt[1]) - 16'h0001)
    else $error("core did not step down by one");

  core_hold_a: assert property (
    s_core_idle |=> $stable(cnt[1]))
    else $error("core moved without an enable");

  // prescaled timer rates for prescale settings 0 and 2
  timer_rate_a: assert property (
    (ctl[1].mode == gptm_pkg::GPTM_TIMER && ctl[1].run && ctl[1].sel == 3'h0)
      |-> en_v[1] == tick)
    else $error("timer mode missed the base rate");

  timer_div_a: assert property (
    (ctl[1].mode == gptm_pkg::GPTM_TIMER && ctl[1].run && ctl[1].sel == 3'h2)
      |-> en_v[1] == (tick && pre_cnt[3:2] == 2'h3))
    else $error("timer mode ignored the prescale");

  gate_open_a: assert property (
    (ctl[1].mode == gptm_pkg::GPTM_GATED && ctl[1].run && ctl[1].sel == 3'h0
      && in_s[1] == ctl[1].gate_hi) |-> en_v[1] == tick)
    else $error("gated timer stalled with gate open");

  // counter mode follows edges of the timer's own sampled pin
  count_edge_a: assert property (
    (ctl[0].mode == gptm_pkg::GPTM_COUNTER && ctl[0].run && ctl[0].sel == 3'h1)
      |-> en_v[0] == (smp_v && in_s[0] && !in_p[0]))
    else $error("counter missed a rising pin edge");

  pin_only_a: assert property (
    (ctl[0].mode == gptm_pkg::GPTM_COUNTER && !ctl[0].sel[2] && en_v[0])
      |-> smp_v && in_s[0] != in_p[0])
    else $error("counter stepped without a pin edge");

  dir_pick_a: assert property (
    (ctl[0].mode != gptm_pkg::GPTM_INCR)
      |-> dn_v[0] == (ctl[0].down ^ (ctl[0].ext_dir && dir_s[0])))
    else $error("direction ignored software or pin");

  // quadrature: one phase moved is a step, both moved is a glitch
  sequence s_one_phase;
    ctl[2].mode == gptm_pkg::GPTM_INCR && ctl[2].run && smp_v
      && in_s[2] != in_p[2] && dir_s[2] == dir_p[2];
  endsequence

  incr_step_a: assert property (
    s_one_phase |-> en_v[2])
    else $error("quadrature step not counted");

  incr_both_a: assert property (
    (ctl[2].mode == gptm_pkg::GPTM_INCR && in_s[2] != in_p[2] && dir_s[2] != dir_p[2])
      |-> !en_v[2])
    else $error("quadrature counted a double change");

  // latch edges as the count source of an auxiliary timer
  lat_clock_a: assert property (
    (ctl[2].mode == gptm_pkg::GPTM_COUNTER && ctl[2].run && ctl[2].sel == 3'h7
      && (lat_r || lat_f)) |-> en_v[2])
    else $error("latch edge did not clock the auxiliary");

  chain_quiet_a: assert property (
    (ctl[2].mode == gptm_pkg::GPTM_COUNTER && ctl[2].sel == 3'h7 && !lat_r && !lat_f)
      |-> !en_v[2])
    else $error("chained auxiliary counted without a latch edge");

  // roles never count
  role_idle_a: assert property (
    (ctl[2].mode == gptm_pkg::GPTM_RELOAD || ctl[2].mode == gptm_pkg::GPTM_CAPTURE)
      |-> !en_v[2])
    else $error("auxiliary counted in a role");

  cap_hold_a: assert property (
    (ctl[2].mode == gptm_pkg::GPTM_CAPTURE && !wr_cnt[2] && !cap[2]) |=> $stable(cnt[2]))
    else $error("capture register moved without a trigger");

  // pwm: aux one loads on latch rise, aux two on latch fall
  sequence s_rise_reload;
    ctl[0].mode == gptm_pkg::GPTM_RELOAD && ctl[0].sel == 3'h5 && lat_r && !wr_cnt[1];
  endsequence

  sequence s_fall_reload;
    ctl[2].mode == gptm_pkg::GPTM_RELOAD && ctl[2].sel == 3'h6 && lat_f
      && !rl[0] && !wr_cnt[1];
  endsequence

  pwm_high_a: assert property (
    s_rise_reload |=> cnt[1] == $past(cnt[0]))
    else $error("latch rise did not reload from aux one");

  pwm_low_a: assert property (
    s_fall_reload |=> cnt[1] == $past(cnt[2]))
    else $error("latch fall did not reload from aux two");

  out_off_a: assert property (
    (ce && !ctl[1].lat_oe) |=> !toggle_output_pin)
    else $error("output pin driven while disabled");

endmodule
`default_nettype wire

/* gptm_pins.sv */
/*
  Pin model of the timer block's outside world: event, gate and
  direction lines. Assumes a free-running clk and one calling process.
*/
`timescale 1ns/100ps
`default_nettype none
module gptm_pins (
  input wire logic clk,
  output logic [2:0] timer_input_pin,
  output logic [2:0] direction_input_pin
);
  // pins idle low and always driven
  initial begin
    timer_input_pin = 3'h0;
    direction_input_pin = 3'h0;
  end
  // n pulses, each level held 10 cycles so a sample sees it
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      repeat (10) @(posedge clk);
      timer_input_pin[idx] <= 1'b1;
      repeat (10) @(posedge clk);
      timer_input_pin[idx] <= 1'b0;
    end
    repeat (10) @(posedge clk);
  endtask
  // static level on an input or direction line
  task automatic level(input int idx, input logic dir, input logic v);
    @(posedge clk);
    if (dir) begin
      direction_input_pin[idx] <= v;
    end else begin
      timer_input_pin[idx] <= v;
    end
  endtask
endmodule
`default_nettype wire

/* tb_general_purpose_timer_module.sv */
/*
  Self-checking bench of the three-timer block: register port traffic,
  wrap, prescale, gate, counter, reload and capture behaviour.
  Assumes the pin model and the design package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_general_purpose_timer_module;
  localparam logic [3:0] ctl_a1 = gptm_pkg::GPTM_CTL0;
  localparam logic [3:0] ctl_c = gptm_pkg::GPTM_CTL0 + 4'h1;
  localparam logic [3:0] ctl_a2 = gptm_pkg::GPTM_CTL0 + 4'h2;
  localparam logic [3:0] cnt_a1 = gptm_pkg::GPTM_CNT0;
  localparam logic [3:0] cnt_c = gptm_pkg::GPTM_CNT0 + 4'h1;
  localparam logic [3:0] cnt_a2 = gptm_pkg::GPTM_CNT0 + 4'h2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  gptm_pkg::gptm_bus_t bus = '0;
  logic [15:0] rd_data;
  logic [15:0] got;
  logic [2:0] tin;
  logic [2:0] dir;
  logic toggle_output_pin;
  int num_errors = 0;
  int total_checks = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  gptm_pins pins (.clk(clk), .timer_input_pin(tin), .direction_input_pin(dir));
  gptm_top dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .bus(bus), .rd_data(rd_data),
    .timer_input_pin(tin), .direction_input_pin(dir), .toggle_output_pin(toggle_output_pin));

  task automatic check(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 got = rd_data;
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd(ctl_c);
    check(got, gptm_pkg::GPTM_CTL_RST);
    rd(cnt_c);
    check(got, gptm_pkg::GPTM_CNT_RST);
    rd(4'hf);
    check(got, 16'h0000);
    check(16'(toggle_output_pin), 16'h0000);
  endtask
  // up past all-ones, then down past zero; latch follows each wrap
  task automatic t_wrap;
    wr(cnt_c, 16'hfffe);
    wr(ctl_c, 16'h0440);
    repeat (40) @(posedge clk);
    wr(ctl_c, 16'h0400);
    rd(cnt_c);
    check(16'(got < 16'h0010), 16'h0001);
    check(16'(toggle_output_pin), 16'h0001);
    rd(gptm_pkg::GPTM_STAT);
    check(16'(got[0]), 16'h0001);
    wr(cnt_c, 16'h0002);
    wr(ctl_c, 16'h04c0);
    repeat (40) @(posedge clk);
    wr(ctl_c, 16'h0400);
    rd(cnt_c);
    check(16'(got > 16'hfff0), 16'h0001);
    check(16'(toggle_output_pin), 16'h0000);
  endtask
  // prescale 2 steps once per 16 cycles
  task automatic t_prescale;
    wr(cnt_c, 16'h0000);
    wr(ctl_c, 16'h0050);
    repeat (160) @(posedge clk);
    wr(ctl_c, 16'h0000);
    rd(cnt_c);
    check(16'(got >= 16'd9 && got <= 16'd11), 16'h0001);
  endtask
  // gate low holds the count, gate high lets it run
  task automatic t_gated;
    wr(cnt_c, 16'h0000);
    wr(ctl_c, 16'h0242);
    repeat (40) @(posedge clk);
    rd(cnt_c);
    check(got, 16'h0000);
    pins.level(1, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    wr(ctl_c, 16'h0000);
    rd(cnt_c);
    check(16'(got >= 16'd7 && got <= 16'd11), 16'h0001);
    pins.level(1, 1'b0, 1'b0);
  endtask
  // pin edges count up, then down with the direction pin high
  task automatic t_counter;
    wr(cnt_a1, 16'h0000);
    wr(ctl_a1, 16'h0049);
    pins.pulse(0, 5);
    rd(cnt_a1);
    check(got, 16'h0005);
    pins.level(0, 1'b1, 1'b1);
    wr(ctl_a1, 16'h0149);
    pins.pulse(0, 3);
    rd(cnt_a1);
    check(got, 16'h0002);
  endtask
  // reload core from aux one, then capture core into aux two
  task automatic t_reload_capture;
    wr(cnt_a1, 16'h1234);
    wr(ctl_a1, 16'h000c);
    pins.pulse(0, 1);
    rd(cnt_c);
    check(got, 16'h1234);
    rd(cnt_a1);
    check(got, 16'h1234);
    wr(cnt_c, 16'habcd);
    wr(ctl_a2, 16'h000d);
    pins.pulse(2, 1);
    rd(cnt_a2);
    check(got, 16'habcd);
  endtask
  // one quadrature cycle on aux two, phase A leading: four steps down
  task automatic t_incr;
    wr(cnt_a2, 16'h0000);
    wr(ctl_a2, 16'h0043);
    pins.level(2, 1'b0, 1'b1);
    repeat (10) @(posedge clk);
    pins.level(2, 1'b1, 1'b1);
    repeat (10) @(posedge clk);
    pins.level(2, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    pins.level(2, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    wr(ctl_a2, 16'h0000);
    rd(cnt_a2);
    check(got, 16'hfffc);
  endtask
  // latch edges clock aux two: two presets give two counts
  task automatic t_latch;
    wr(cnt_a2, 16'h0000);
    wr(ctl_a2, 16'h0079);
    wr(gptm_pkg::GPTM_STAT, 16'h0001);
    rd(gptm_pkg::GPTM_STAT);
    check(16'(got[0]), 16'h0001);
    check(16'(toggle_output_pin), 16'h0000);
    wr(gptm_pkg::GPTM_STAT, 16'h0000);
    repeat (4) @(posedge clk);
    rd(cnt_a2);
    check(got, 16'h0002);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_wrap();
    t_prescale();
    t_gated();
    t_counter();
    t_reload_capture();
    t_incr();
    t_latch();
    test_done();
  end
  // watchdog against a hang
  initial begin
    #(100 * 20000);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
